// >>> hdl/dsbw_regs.vh
// Purpose: Constants for the byte-lane masked DDR SRAM write port
// Assumes: Included by the write-port top, its buffer and its array
// Notes: Array depth is kept small so the model stays synthesizable
`ifndef DSBW_REGS_VH
`define DSBW_REGS_VH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define DSBW_ADDR_W 6
`define DSBW_DATA_W 36
`define DSBW_LANES 4
`define DSBW_LANE_W 9
`define DSBW_ENTRY_W 46

// ------------------------------------------------------------
// Word-width configuration codes and the lanes each one uses
// ------------------------------------------------------------
`define DSBW_CFG_X9 2'h0
`define DSBW_CFG_X18 2'h1
`define DSBW_CFG_X36 2'h2
`define DSBW_LANES_X9 4'h1
`define DSBW_LANES_X18 4'h3
`define DSBW_LANES_X36 4'hf

// ------------------------------------------------------------
// Write sequencer states
// ------------------------------------------------------------
`define DSBW_ST_IDLE 2'h0
`define DSBW_ST_BEAT1 2'h1
`define DSBW_ST_PUSH0 2'h2
`define DSBW_ST_PUSH1 2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DSBW_RST_WORD 36'h0_0000_0000
`define DSBW_RST_MASK 4'hf

`endif

// >>> hdl/dsbw_mem.v
// Purpose: Storage array with per-lane write enables and registered read
// Assumes: One access per cycle, chosen by the caller
// Notes: Lanes without an enable keep their stored bits
`include "dsbw_regs.vh"
`default_nettype none

module dsbw_mem (
    // Clock
    input wire clk,
    // Write side
    input wire wr_en,
    input wire [`DSBW_ADDR_W-1:0] wr_addr,
    input wire [`DSBW_DATA_W-1:0] wr_data,
    input wire [`DSBW_LANES-1:0] wr_lane_en,
    // Read side
    input wire rd_en,
    input wire [`DSBW_ADDR_W-1:0] rd_addr,
    output reg [`DSBW_DATA_W-1:0] rd_data
);

    reg [`DSBW_DATA_W-1:0] array [0:(1<<`DSBW_ADDR_W)-1];
    integer lane;

    // ------------------------------------------------------------
    // Lane-merged write and registered read
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (wr_en) begin
            for (lane = 0; lane < `DSBW_LANES; lane = lane + 1) begin
                if (wr_lane_en[lane]) begin
                    array[wr_addr][lane*`DSBW_LANE_W +: `DSBW_LANE_W] <=
                        wr_data[lane*`DSBW_LANE_W +: `DSBW_LANE_W];
                end
            end
        end
        if (rd_en) begin
            rd_data <= array[rd_addr];
        end
    end

endmodule // dsbw_mem

`default_nettype wire

// >>> hdl/dsbw_buf.v
// Purpose: Two-entry buffer between beat capture and the array
// Assumes: Synchronous active-high reset
// Notes: Full and empty are exact; a stalled drain fills it
`include "dsbw_regs.vh"
`default_nettype none

module dsbw_buf (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [`DSBW_ENTRY_W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [`DSBW_ENTRY_W-1:0] out_data
);

    reg [`DSBW_ENTRY_W-1:0] slot0;
    reg [`DSBW_ENTRY_W-1:0] slot1;
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = rd_ptr ? slot1 : slot0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ------------------------------------------------------------
    // Pointers and storage
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

    always @(posedge clk) begin
        if (push && !wr_ptr) begin
            slot0 <= in_data;
        end
        if (push && wr_ptr) begin
            slot1 <= in_data;
        end
    end

endmodule // dsbw_buf

`default_nettype wire

// >>> hdl/dsbw_top.v
// Purpose: Byte-lane masked write port of a two-word-burst DDR SRAM
// Assumes: Rising edges of both input clocks arrive as strobes on clk
// Notes: Reads take the array first; queued writes wait in the buffer
`include "dsbw_regs.vh"
`default_nettype none

module dsbw_top (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Configuration
    input wire [1:0] cfg_width,
    // Input clock edge strobes
    input wire k_rise,
    input wire k_n_rise,
    // Write port
    input wire write_port_select_n,
    input wire [`DSBW_ADDR_W-1:0] wr_addr,
    input wire [`DSBW_DATA_W-1:0] wr_data,
    input wire [`DSBW_LANES-1:0] lane_write_mask_n,
    output reg wr_busy,
    // Read port
    input wire rd_req,
    input wire [`DSBW_ADDR_W-1:0] rd_addr,
    output reg [`DSBW_DATA_W-1:0] rd_data,
    output reg rd_oe
);

    // ------------------------------------------------------------
    // Lane enables from active-low masks and word width
    // ------------------------------------------------------------
    function [`DSBW_LANES-1:0] lane_enable;
        input [`DSBW_LANES-1:0] mask_n;
        input [1:0] cfg;
        reg [`DSBW_LANES-1:0] used;
        begin
            if (cfg == `DSBW_CFG_X9) begin
                used = `DSBW_LANES_X9;
            end else if (cfg == `DSBW_CFG_X18) begin
                used = `DSBW_LANES_X18;
            end else begin
                used = `DSBW_LANES_X36;
            end
            lane_enable = ~mask_n & used;
        end
    endfunction

    reg [1:0] state;
    reg [`DSBW_DATA_W-1:0] beat0_data;
    reg [`DSBW_LANES-1:0] beat0_mask_n;
    reg [`DSBW_DATA_W-1:0] beat1_data;
    reg [`DSBW_LANES-1:0] beat1_mask_n;
    reg [`DSBW_ADDR_W-1:0] burst_addr;
    reg rd_pending;
    reg [1:0] next_state;
    reg push_valid;
    reg [`DSBW_ENTRY_W-1:0] push_entry;
    wire push_ready;
    wire head_valid;
    wire [`DSBW_ENTRY_W-1:0] head_entry;
    wire drain;
    wire [`DSBW_DATA_W-1:0] mem_rdata;
    wire [`DSBW_ADDR_W-1:0] next_addr;

    assign next_addr = burst_addr + {{(`DSBW_ADDR_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        push_valid = 1'b0;
        push_entry = {`DSBW_ENTRY_W{1'b0}};
        case (state)
            `DSBW_ST_IDLE: begin
                if (k_rise && !write_port_select_n) begin
                    next_state = `DSBW_ST_BEAT1;
                end
            end
            `DSBW_ST_BEAT1: begin
                if (k_n_rise) begin
                    next_state = `DSBW_ST_PUSH0;
                end
            end
            `DSBW_ST_PUSH0: begin
                push_valid = 1'b1;
                push_entry = {burst_addr, beat0_mask_n, beat0_data};
                if (push_ready) begin
                    next_state = `DSBW_ST_PUSH1;
                end
            end
            default: begin
                push_valid = 1'b1;
                push_entry = {next_addr, beat1_mask_n, beat1_data};
                if (push_ready) begin
                    next_state = `DSBW_ST_IDLE;
                end
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state <= `DSBW_ST_IDLE;
            wr_busy <= 1'b0;
            beat0_data <= `DSBW_RST_WORD;
            beat0_mask_n <= `DSBW_RST_MASK;
            beat1_data <= `DSBW_RST_WORD;
            beat1_mask_n <= `DSBW_RST_MASK;
            burst_addr <= {`DSBW_ADDR_W{1'b0}};
        end else begin
            state <= next_state;
            wr_busy <= (next_state != `DSBW_ST_IDLE);
            if (state == `DSBW_ST_IDLE && k_rise && !write_port_select_n) begin
                beat0_data <= wr_data;
                beat0_mask_n <= lane_write_mask_n;
            end
            if (state == `DSBW_ST_BEAT1 && k_n_rise) begin
                burst_addr <= wr_addr;
                beat1_data <= wr_data;
                beat1_mask_n <= lane_write_mask_n;
            end
        end
    end

    // ------------------------------------------------------------
    // Write buffer; a read in the same cycle stalls the drain
    // ------------------------------------------------------------
    assign drain = head_valid && !rd_req;

    dsbw_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_entry),
        .out_valid(head_valid),
        .out_ready(!rd_req),
        .out_data(head_entry)
    );

    // ------------------------------------------------------------
    // Array with lane-masked merge
    // ------------------------------------------------------------
    dsbw_mem u_mem (
        .clk(clk),
        .wr_en(drain),
        .wr_addr(head_entry[`DSBW_ENTRY_W-1 -: `DSBW_ADDR_W]),
        .wr_data(head_entry[`DSBW_DATA_W-1:0]),
        .wr_lane_en(lane_enable(head_entry[`DSBW_DATA_W +: `DSBW_LANES], cfg_width)),
        .rd_en(rd_req),
        .rd_addr(rd_addr),
        .rd_data(mem_rdata)
    );

    // ------------------------------------------------------------
    // Read data register; not driven until a read completes
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_pending <= 1'b0;
            rd_data <= `DSBW_RST_WORD;
            rd_oe <= 1'b0;
        end else begin
            rd_pending <= rd_req;
            rd_oe <= rd_pending;
            if (rd_pending) begin
                rd_data <= mem_rdata;
            end
        end
    end

endmodule // dsbw_top

`default_nettype wire

// >>> tb/dsbw_top_monitor.sv
// Purpose: Port-level checks of the masked write port
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to every dsbw_top instance
`include "dsbw_regs.vh"
`default_nettype none
module dsbw_top_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Write port
    input wire logic k_rise,
    input wire logic k_n_rise,
    input wire logic write_port_select_n,
    input wire logic wr_busy,
    // Read port
    input wire logic rd_req,
    input wire logic [`DSBW_DATA_W-1:0] rd_data,
    input wire logic rd_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_beat0;
        k_rise && !write_port_select_n && !wr_busy;
    endsequence
    sequence s_answer;
        ##2 rd_oe;
    endsequence
    a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) sys_rst |=>
        !wr_busy && !rd_oe && rd_data == 36'h0_0000_0000) else $error("not quiet after reset");
    a_busy_start: assert property (s_beat0 |=> wr_busy) else $error("burst not taken");
    a_busy_hold: assert property ($rose(wr_busy) |-> wr_busy[*2]) else $error("busy short");
    a_busy_ends: assert property ($rose(wr_busy) |-> ##[1:20] !wr_busy)
        else $error("pending write never ends");
    a_desel_idle: assert property (!wr_busy && !(k_rise && !write_port_select_n) |=>
        !wr_busy) else $error("busy without select");
    a_read_lat: assert property (rd_req |-> s_answer) else $error("read answer late");
    a_no_spur: assert property (rd_oe |-> $past(rd_req, 2)) else $error("answer unasked");
    a_data_hold: assert property (!rd_oe |-> $stable(rd_data)) else $error("read data moved");
endmodule // dsbw_top_monitor
bind dsbw_top dsbw_top_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .k_rise(k_rise),
    .k_n_rise(k_n_rise), .write_port_select_n(write_port_select_n), .wr_busy(wr_busy),
    .rd_req(rd_req), .rd_data(rd_data), .rd_oe(rd_oe));
`default_nettype wire

// >>> tb/dsbw_ctl_model.sv
// Purpose: Memory controller driving the write port
// Assumes: Edge strobes stand for the two input clocks
// Notes: Released lines show the inverse of their last value
`default_nettype none
module dsbw_ctl_model (
    // Clock
    input wire logic clk,
    // Write port
    output logic k_rise,
    output logic k_n_rise,
    output logic write_port_select_n,
    output logic [5:0] wr_addr,
    output logic [35:0] wr_data,
    output logic [3:0] lane_write_mask_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobes stay low between bursts: clocks parked
    initial begin
        k_rise = 0;
        k_n_rise = 0;
        write_port_select_n = 1;
        wr_addr = 6'h00;
        wr_data = 36'h0_0000_0000;
        lane_write_mask_n = 4'hf;
    end
    task automatic burst(input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
        input logic [35:0] d1, input logic [3:0] m1, input logic sel_n);
        @(negedge clk);
        k_rise = 1;
        write_port_select_n = sel_n;
        wr_data = d0;
        lane_write_mask_n = m0;
        wr_addr = ~a;
        @(negedge clk);
        k_rise = 0;
        write_port_select_n = 1;
        k_n_rise = 1;
        wr_addr = a;
        wr_data = d1;
        lane_write_mask_n = m1;
        @(negedge clk);
        k_n_rise = 0;
        wr_data = ~d1;
        lane_write_mask_n = ~m1;
        wr_addr = ~a;
    endtask
endmodule // dsbw_ctl_model
`default_nettype wire

// >>> tb/dsbw_top_tb.sv
// Purpose: Self-checking bench of the masked write port
// Assumes: Every address read is written by the bench before it is judged
// Notes: Expected words kept in a shadow array
`default_nettype none
module dsbw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, rd_req = 0;
    logic [1:0] cfg_width = 2'h2;
    logic [5:0] rd_addr = 6'h00;
    wire logic k_rise, k_n_rise, sel_n, wr_busy, rd_oe;
    wire logic [5:0] wr_addr;
    wire logic [35:0] wr_data, rd_data;
    wire logic [3:0] mask_n;
    logic [35:0] shadow [0:63];
    int errors = 0, num_checks = 0;
    always #5 clk = ~clk;
    dsbw_top dut (.clk(clk), .sys_rst(sys_rst), .cfg_width(cfg_width), .k_rise(k_rise),
        .k_n_rise(k_n_rise), .write_port_select_n(sel_n), .wr_addr(wr_addr),
        .wr_data(wr_data), .lane_write_mask_n(mask_n), .wr_busy(wr_busy), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_oe(rd_oe));
    dsbw_ctl_model ctl (.clk(clk), .k_rise(k_rise), .k_n_rise(k_n_rise),
        .write_port_select_n(sel_n), .wr_addr(wr_addr), .wr_data(wr_data),
        .lane_write_mask_n(mask_n));
    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic upd(input logic [5:0] a, input logic [35:0] d, input logic [3:0] m);
        int nl;
        nl = (cfg_width == 2'h0) ? 1 : (cfg_width == 2'h1) ? 2 : 4;
        for (int i = 0; i < nl; i++) if (!m[i]) shadow[a][9*i+:9] = d[9*i+:9];
    endtask
    task automatic idle_wait();
        for (int n = 0; n < 50 && wr_busy !== 1'b0; n++) @(negedge clk);
        chk_bit(wr_busy, 1'b0);
    endtask
    task automatic wr(input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
        input logic [35:0] d1, input logic [3:0] m1, input logic sel_n = 0);
        idle_wait();
        ctl.burst(a, d0, m0, d1, m1, sel_n);
        if (!sel_n) begin
            upd(a, d0, m0);
            upd(a + 6'h01, d1, m1);
        end
        idle_wait();
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge clk);
        rd_req = 1;
        rd_addr = a;
        @(negedge clk);
        rd_req = 0;
        @(posedge clk);
        #1;
        chk_bit(rd_oe, 1'b1);
        chk_word(rd_data, shadow[a]);
    endtask
    task automatic rd2(input logic [5:0] a);
        rd(a);
        rd(a + 6'h01);
    endtask
    task automatic t_reset();
        chk_bit(wr_busy, 1'b0);
        chk_bit(rd_oe, 1'b0);
        chk_word(rd_data, 36'h0_0000_0000);
    endtask
    task automatic t_x36();
        cfg_width = 2'h2;
        wr(6'h04, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
        rd2(6'h04);
        for (int i = 0; i < 4; i++) begin
            wr(6'h04, 36'ha_aaaa_aaaa ^ i, ~(4'h1 << i), 36'h5_5555_5555, ~(4'h8 >> i));
            rd2(6'h04);
        end
        wr(6'h04, 36'hf_ffff_ffff, 4'hf, 36'h0_0000_0000, 4'hf);
        rd2(6'h04);
    endtask
    task automatic t_x18();
        cfg_width = 2'h2;
        wr(6'h08, 36'h0_0000_0000, 4'h0, 36'h0_0000_0000, 4'h0);
        cfg_width = 2'h1;
        for (int m = 0; m < 4; m++) begin
            wr(6'h08, 36'h3_c3c3_c3c3 + m, {2'b00, m[1:0]}, 36'hc_3c3c_3c3c,
                {2'b00, ~m[1:0]});
            rd2(6'h08);
        end
    endtask
    task automatic t_x9();
        cfg_width = 2'h2;
        wr(6'h0c, 36'h0_0000_0000, 4'h0, 36'h0_0000_0000, 4'h0);
        cfg_width = 2'h0;
        wr(6'h0c, 36'hf_ffff_ffff, 4'h0, 36'hf_ffff_ffff, 4'hf);
        rd2(6'h0c);
    endtask
    task automatic t_wrap_desel();
        cfg_width = 2'h2;
        wr(6'h3f, 36'h7_0f0f_0f0f, 4'h0, 36'h8_f0f0_f0f0, 4'h0);
        wr(6'h3f, 36'h1_1111_1111, 4'h0, 36'h2_2222_2222, 4'h0, 1'b1);
        rd(6'h3f);
        rd(6'h00);
    endtask
    task automatic t_stall();
        fork
            begin
                wr(6'h10, 36'h4_4444_4444, 4'h0, 36'h6_6666_6666, 4'h0);
                wr(6'h12, 36'h9_9999_9999, 4'h0, 36'hb_bbbb_bbbb, 4'h0);
            end
            begin
                @(negedge clk);
                rd_req = 1;
                rd_addr = 6'h04;
                repeat (7) @(negedge clk);
                rd_req = 0;
            end
        join
        repeat (6) @(posedge clk);
        rd2(6'h10);
        rd2(6'h12);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        t_reset();
        t_x36();
        t_x18();
        t_x9();
        t_wrap_desel();
        t_stall();
        stop_test();
    end
endmodule // dsbw_top_tb
`default_nettype wire
